// >>> common/aad_pkg.sv
// constants, field positions and encodings for the add/add_with_carry_op/and slice
// assumes a 24-bit instruction word handed in on the core clock
package aad_pkg;
  localparam int DW = 16;
  localparam int NREG = 16;
  localparam int IDX_W = 4;
  localparam int DADDR_W = 13;
  localparam int INSTR_W = 24;
  // instruction fields
  localparam int OPC_MSB = 23;
  localparam int OPC_LSB = 16;
  localparam int FAM_MSB = 23;
  localparam int FAM_LSB = 22;
  localparam int FORM_MSB = 21;
  localparam int FORM_LSB = 19;
  localparam int WB_MSB = 18;
  localparam int WB_LSB = 15;
  localparam int BYTE_BIT = 14;
  localparam int WDM_MSB = 13;
  localparam int WDM_LSB = 11;
  localparam int WD_MSB = 10;
  localparam int WD_LSB = 7;
  localparam int WSM_MSB = 6;
  localparam int WSM_LSB = 4;
  localparam int WS_MSB = 3;
  localparam int WS_LSB = 0;
  localparam int L10_MSB = 13;
  localparam int L10_LSB = 4;
  localparam int L5_MSB = 4;
  localparam int L5_LSB = 0;
  localparam int FA_MSB = 12;
  localparam int FA_LSB = 0;
  // families and forms
  localparam logic [1:0] FAM_ADD = 2'h0;
  localparam logic [1:0] FAM_ADD_WITH_CARRY_OP = 2'h1;
  localparam logic [1:0] FAM_AND = 2'h2;
  localparam logic [2:0] FORM_F_TO_F = 3'h0;
  localparam logic [2:0] FORM_F_TO_ACC = 3'h1;
  localparam logic [2:0] FORM_TEN_BIT_IMMEDIATE = 3'h2;
  localparam logic [2:0] FORM_REG = 3'h3;
  localparam logic [2:0] FORM_SHORT_IMMEDIATE = 3'h4;
  // addressing modes
  localparam logic [2:0] AM_DIRECT = 3'h0;
  localparam logic [2:0] AM_IND = 3'h1;
  localparam logic [2:0] AM_POSTINC = 3'h2;
  localparam logic [2:0] AM_POSTDEC = 3'h3;
  localparam logic [2:0] AM_PREINC = 3'h4;
  localparam logic [2:0] AM_PREDEC = 3'h5;
  localparam logic [IDX_W-1:0] ACC_IDX = 4'h0;
  localparam logic [DW-1:0] STEP_BYTE = 16'h0001;
  localparam logic [DW-1:0] STEP_WORD = 16'h0002;
  localparam logic [DW-1:0] DEFAULT_ACCUMULATOR_REG_RESET = 16'h0000;
  // status layout
  localparam int SR_C = 0;
  localparam int SR_DC = 1;
  localparam int SR_N = 2;
  localparam int SR_OV = 3;
  localparam int SR_Z = 4;
  localparam int SR_W = 5;
  localparam logic [SR_W-1:0] SR_RESET = 5'h00;
  // apb map
  localparam logic [7:0] A_STATUS = 8'h00;
  localparam logic [7:0] A_RESULT = 8'h04;
  localparam logic [7:0] A_COUNT = 8'h08;
  localparam logic [7:0] A_INSTR = 8'h0c;
  localparam logic [1:0] A_DEFAULT_ACCUMULATOR_REG_TOP = 2'h1;
  localparam logic [1:0] BE_LO = 2'h1;
  localparam logic [1:0] BE_HI = 2'h2;
  localparam logic [1:0] BE_ALL = 2'h3;
endpackage

// >>> src/aad_alu.sv
// adder and and unit with flag generation, byte or word size
// assumes operands arrive already zero-extended in byte mode
`timescale 1ns/1ps
module aad_alu
  import aad_pkg::*;
(
  input wire logic [DW-1:0] opa,
  input wire logic [DW-1:0] opb,
  input wire logic cin,
  input wire logic byte_op,
  input wire logic and_op,
  output logic [DW-1:0] res,
  output logic c,
  output logic dc,
  output logic n,
  output logic ov,
  output logic zero
);
  logic [DW:0] sum;
  logic [8:0] lo;
  logic [4:0] nib;
  logic [DW-1:0] raw;

  // sums with carry in and the flag terms
  always_comb begin
    sum = {1'b0, opa} + {1'b0, opb} + {{DW{1'b0}}, cin};
    lo = {1'b0, opa[7:0]} + {1'b0, opb[7:0]} + {8'h00, cin};
    nib = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
    raw = and_op ? (opa & opb) : sum[DW-1:0];
    res = byte_op ? {8'h00, raw[7:0]} : raw;
    c = byte_op ? lo[8] : sum[DW];
    dc = byte_op ? nib[4] : lo[8];
    n = byte_op ? res[7] : res[DW-1];
    if (byte_op) begin
      ov = (opa[7] == opb[7]) && (res[7] != opa[7]);
      zero = (res[7:0] == 8'h00);
    end else begin
      ov = (opa[DW-1] == opb[DW-1]) && (res[DW-1] != opa[DW-1]);
      zero = (res == 16'h0000);
    end
  end
endmodule

// >>> src/aad_regfile.sv
// sixteen working registers in flip-flops with four write ports
// assumes one writer per port per cycle; later ports win
`timescale 1ns/1ps
module aad_regfile
  import aad_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sw_we,
  input wire logic [IDX_W-1:0] sw_idx,
  input wire logic [DW-1:0] sw_data,
  input wire logic sp_we,
  input wire logic [IDX_W-1:0] sp_idx,
  input wire logic [DW-1:0] sp_data,
  input wire logic dp_we,
  input wire logic [IDX_W-1:0] dp_idx,
  input wire logic [DW-1:0] dp_data,
  input wire logic res_we,
  input wire logic [IDX_W-1:0] res_idx,
  input wire logic [1:0] res_be,
  input wire logic [DW-1:0] res_data,
  output logic [NREG*DW-1:0] regs_flat
);
  // one entry per register: software, pointers, then result
  for (genvar i = 0; i < NREG; i++) begin : g_ent
    logic [DW-1:0] q_reg;
    logic [DW-1:0] q_next;
    always_comb begin
      q_next = q_reg;
      if (sw_we && sw_idx == IDX_W'(i)) begin
        q_next = sw_data;
      end
      if (sp_we && sp_idx == IDX_W'(i)) begin
        q_next = sp_data;
      end
      if (dp_we && dp_idx == IDX_W'(i)) begin
        q_next = dp_data;
      end
      if (res_we && res_idx == IDX_W'(i)) begin
        if (res_be[0]) begin
          q_next[7:0] = res_data[7:0];
        end
        if (res_be[1]) begin
          q_next[15:8] = res_data[15:8];
        end
      end
    end
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        q_reg <= DEFAULT_ACCUMULATOR_REG_RESET;
      end else begin
        q_reg <= q_next;
      end
    end
    assign regs_flat[i*DW +: DW] = q_reg;
  end
endmodule

// >>> src/aad_datapath.sv
// add, add-with-carry and and datapath slice, apb register access
// assumes instruction word and memory read data on MCLK, memory
// read is combinational, memory write taken at the next edge
`timescale 1ns/1ps
module aad_datapath
  import aad_pkg::*;
#(
  parameter int AW = DADDR_W
)
(
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic [7:0] PADDR,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic INSTR_VALID,
  input wire logic [INSTR_W-1:0] INSTR_WORD,
  output logic INSTR_ILLEGAL,
  output logic [AW-1:0] DM_RADDR,
  input wire logic [DW-1:0] DM_RDATA,
  output logic DM_WE,
  output logic [AW-1:0] DM_WADDR,
  output logic [1:0] DM_WBE,
  output logic [DW-1:0] DM_WDATA,
  output logic [SR_W-1:0] STATUS_FLAGS
);
  logic [NREG*DW-1:0] regs_flat;
  logic [DW-1:0] default_accumulator_reg [NREG];
  logic [1:0] fam;
  logic [2:0] form;
  logic [IDX_W-1:0] wb_idx;
  logic [IDX_W-1:0] ws_idx;
  logic [IDX_W-1:0] wd_idx;
  logic [2:0] ws_mode;
  logic [2:0] wd_mode;
  logic [9:0] ten_bit_immediate;
  logic [4:0] short_immediate;
  logic [AW-1:0] faddr;
  logic byte_op;
  logic legal;
  logic go;
  logic [DW-1:0] step;
  logic [DW-1:0] ea_s;
  logic [DW-1:0] ea_d;
  logic [DW-1:0] opa;
  logic [DW-1:0] opb;
  logic [DW-1:0] mem_word;
  logic [DW-1:0] mem_val;
  logic [AW-1:0] mem_addr;
  logic use_mem;
  logic dst_mem;
  logic [AW-1:0] dst_addr;
  logic [IDX_W-1:0] dst_idx;
  logic src_mod;
  logic dst_mod;
  logic [DW-1:0] alu_res;
  logic alu_c;
  logic alu_dc;
  logic alu_n;
  logic alu_ov;
  logic alu_zero;
  logic [SR_W-1:0] sr_reg;
  logic [SR_W-1:0] sr_next;
  logic [DW-1:0] result_reg;
  logic [DW-1:0] result_next;
  logic [31:0] count_reg;
  logic [31:0] count_next;
  logic [INSTR_W-1:0] last_reg;
  logic [INSTR_W-1:0] last_next;
  logic illegal_reg;
  logic illegal_next;
  logic pend_reg;
  logic pend_next;
  logic [AW-1:0] paddr_reg;
  logic [AW-1:0] paddr_next;
  logic [1:0] pbe_reg;
  logic [1:0] pbe_next;
  logic [DW-1:0] pdata_reg;
  logic [DW-1:0] pdata_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic apb_wr;
  logic is_default_accumulator_reg;
  logic mapped;
  logic sw_we;

  // effective address: pre-modified modes move before use
  function automatic logic [DW-1:0] eff_addr(input logic [2:0] m,
                                             input logic [DW-1:0] p,
                                             input logic [DW-1:0] s);
    logic [DW-1:0] a;
    a = p;
    if (m == AM_PREINC) begin
      a = p + s;
    end else if (m == AM_PREDEC) begin
      a = p - s;
    end
    return a;
  endfunction

  // pointer value after the access
  function automatic logic [DW-1:0] new_ptr(input logic [2:0] m,
                                            input logic [DW-1:0] p,
                                            input logic [DW-1:0] s);
    logic [DW-1:0] a;
    a = p;
    if (m == AM_POSTINC || m == AM_PREINC) begin
      a = p + s;
    end else if (m == AM_POSTDEC || m == AM_PREDEC) begin
      a = p - s;
    end
    return a;
  endfunction

  function automatic logic is_ind(input logic [2:0] m);
    return m inside {AM_IND, AM_POSTINC, AM_POSTDEC, AM_PREINC, AM_PREDEC};
  endfunction

  function automatic logic modifies(input logic [2:0] m);
    return m inside {AM_POSTINC, AM_POSTDEC, AM_PREINC, AM_PREDEC};
  endfunction

  // unpack the register file
  for (genvar i = 0; i < NREG; i++) begin : g_rd
    assign default_accumulator_reg[i] = regs_flat[i*DW +: DW];
  end

  // instruction fields
  assign fam = INSTR_WORD[FAM_MSB:FAM_LSB];
  assign form = INSTR_WORD[FORM_MSB:FORM_LSB];
  assign wb_idx = INSTR_WORD[WB_MSB:WB_LSB];
  assign ws_idx = INSTR_WORD[WS_MSB:WS_LSB];
  assign wd_idx = INSTR_WORD[WD_MSB:WD_LSB];
  assign ws_mode = INSTR_WORD[WSM_MSB:WSM_LSB];
  assign wd_mode = INSTR_WORD[WDM_MSB:WDM_LSB];
  assign ten_bit_immediate = INSTR_WORD[L10_MSB:L10_LSB];
  assign short_immediate = INSTR_WORD[L5_MSB:L5_LSB];
  assign faddr = INSTR_WORD[FA_MSB:FA_LSB];
  assign byte_op = INSTR_WORD[BYTE_BIT];

  // operand selection, addressing and destination decode
  always_comb begin
    legal = (fam == FAM_ADD || fam == FAM_ADD_WITH_CARRY_OP || fam == FAM_AND) &&
            (form inside {FORM_F_TO_F, FORM_F_TO_ACC, FORM_TEN_BIT_IMMEDIATE,
                          FORM_REG, FORM_SHORT_IMMEDIATE});
    go = INSTR_VALID && legal;
    step = byte_op ? STEP_BYTE : STEP_WORD;
    ea_s = eff_addr(ws_mode, default_accumulator_reg[ws_idx], step);
    ea_d = eff_addr(wd_mode, default_accumulator_reg[wd_idx], step);
    opa = 16'h0000;
    opb = 16'h0000;
    mem_addr = ea_s[AW-1:0];
    use_mem = 1'b0;
    dst_mem = 1'b0;
    dst_addr = ea_d[AW-1:0];
    dst_idx = wd_idx;
    src_mod = 1'b0;
    dst_mod = 1'b0;
    case (form)
      FORM_F_TO_F: begin
        opa = default_accumulator_reg[ACC_IDX];
        mem_addr = faddr;
        use_mem = 1'b1;
        dst_mem = 1'b1;
        dst_addr = faddr;
      end
      FORM_F_TO_ACC: begin
        opa = default_accumulator_reg[ACC_IDX];
        mem_addr = faddr;
        use_mem = 1'b1;
        dst_idx = ACC_IDX;
      end
      FORM_TEN_BIT_IMMEDIATE: begin
        opa = default_accumulator_reg[ws_idx];
        // byte size keeps the literal to 0..255
        opb = byte_op ? {8'h00, ten_bit_immediate[7:0]} :
                        {6'h00, ten_bit_immediate};
        dst_idx = ws_idx;
      end
      FORM_REG: begin
        opa = default_accumulator_reg[wb_idx];
        opb = default_accumulator_reg[ws_idx];
        use_mem = is_ind(ws_mode);
        src_mod = modifies(ws_mode);
        dst_mem = is_ind(wd_mode);
        dst_mod = modifies(wd_mode);
      end
      FORM_SHORT_IMMEDIATE: begin
        opa = default_accumulator_reg[wb_idx];
        opb = {11'h000, short_immediate};
        dst_mem = is_ind(wd_mode);
        dst_mod = modifies(wd_mode);
      end
      default: begin
        opa = 16'h0000;
      end
    endcase
    // forward a write still waiting for the memory edge
    mem_word = DM_RDATA;
    if (pend_reg && paddr_reg[AW-1:1] == mem_addr[AW-1:1]) begin
      if (pbe_reg[0]) begin
        mem_word[7:0] = pdata_reg[7:0];
      end
      if (pbe_reg[1]) begin
        mem_word[15:8] = pdata_reg[15:8];
      end
    end
    mem_val = mem_word;
    if (byte_op) begin
      mem_val = {8'h00, mem_addr[0] ? mem_word[15:8] : mem_word[7:0]};
    end
    if (use_mem) begin
      opb = mem_val;
    end
    if (byte_op) begin
      opa = {8'h00, opa[7:0]};
      opb = {8'h00, opb[7:0]};
    end
  end

  assign DM_RADDR = mem_addr;

  aad_alu u_alu (
    .opa(opa),
    .opb(opb),
    .cin((fam == FAM_ADD_WITH_CARRY_OP) && sr_reg[SR_C]),
    .byte_op(byte_op),
    .and_op(fam == FAM_AND),
    .res(alu_res),
    .c(alu_c),
    .dc(alu_dc),
    .n(alu_n),
    .ov(alu_ov),
    .zero(alu_zero)
  );

  // apb decode
  assign apb_wr = PSEL && PENABLE && PWRITE;
  assign is_default_accumulator_reg = (PADDR[7:6] == A_DEFAULT_ACCUMULATOR_REG_TOP) && (PADDR[1:0] == 2'h0);
  assign mapped = is_default_accumulator_reg || PADDR inside {A_STATUS, A_RESULT, A_COUNT,
                                           A_INSTR};
  assign sw_we = apb_wr && is_default_accumulator_reg;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;

  aad_regfile u_regs (
    .clk(MCLK),
    .rst_n(RSTN),
    .sw_we(sw_we),
    .sw_idx(PADDR[5:2]),
    .sw_data(PWDATA[DW-1:0]),
    .sp_we(go && src_mod),
    .sp_idx(ws_idx),
    .sp_data(new_ptr(ws_mode, default_accumulator_reg[ws_idx], step)),
    .dp_we(go && dst_mod),
    .dp_idx(wd_idx),
    .dp_data(new_ptr(wd_mode, default_accumulator_reg[wd_idx], step)),
    .res_we(go && !dst_mem),
    .res_idx(dst_idx),
    .res_be(byte_op ? BE_LO : BE_ALL),
    .res_data(alu_res),
    .regs_flat(regs_flat)
  );

  // status, result, counters
  always_comb begin
    sr_next = sr_reg;
    result_next = result_reg;
    count_next = count_reg;
    last_next = last_reg;
    illegal_next = INSTR_VALID && !legal;
    if (go) begin
      result_next = alu_res;
      count_next = count_reg + 32'h0000_0001;
      last_next = INSTR_WORD;
      sr_next[SR_N] = alu_n;
      if (fam == FAM_AND) begin
        sr_next[SR_Z] = alu_zero;
      end else begin
        sr_next[SR_C] = alu_c;
        sr_next[SR_DC] = alu_dc;
        sr_next[SR_OV] = alu_ov;
        // carry chain keeps zero sticky across words
        sr_next[SR_Z] = (fam == FAM_ADD_WITH_CARRY_OP) ? (sr_reg[SR_Z] && alu_zero) :
                                            alu_zero;
      end
    end else if (apb_wr && PADDR == A_STATUS) begin
      sr_next = PWDATA[SR_W-1:0];
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      sr_reg <= SR_RESET;
      result_reg <= 16'h0000;
      count_reg <= 32'h0000_0000;
      last_reg <= 24'h00_0000;
      illegal_reg <= 1'b0;
    end else begin
      sr_reg <= sr_next;
      result_reg <= result_next;
      count_reg <= count_next;
      last_reg <= last_next;
      illegal_reg <= illegal_next;
    end
  end

  // memory write, issued on the edge after execution
  always_comb begin
    pend_next = go && dst_mem;
    paddr_next = paddr_reg;
    pbe_next = pbe_reg;
    pdata_next = pdata_reg;
    if (go && dst_mem) begin
      paddr_next = dst_addr;
      pbe_next = BE_ALL;
      pdata_next = alu_res;
      if (byte_op) begin
        pbe_next = dst_addr[0] ? BE_HI : BE_LO;
        pdata_next = {alu_res[7:0], alu_res[7:0]};
      end
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      pend_reg <= 1'b0;
      paddr_reg <= '0;
      pbe_reg <= 2'h0;
      pdata_reg <= 16'h0000;
    end else begin
      pend_reg <= pend_next;
      paddr_reg <= paddr_next;
      pbe_reg <= pbe_next;
      pdata_reg <= pdata_next;
    end
  end

  // read data captured in the setup phase
  always_comb begin
    prdata_next = prdata_reg;
    if (PSEL && !PENABLE) begin
      prdata_next = 32'h0000_0000;
      if (is_default_accumulator_reg) begin
        prdata_next = {16'h0000, default_accumulator_reg[PADDR[5:2]]};
      end else begin
        case (PADDR)
          A_STATUS: prdata_next = {27'h000_0000, sr_reg};
          A_RESULT: prdata_next = {16'h0000, result_reg};
          A_COUNT: prdata_next = count_reg;
          A_INSTR: prdata_next = {8'h00, last_reg};
          default: prdata_next = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      prdata_reg <= 32'h0000_0000;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  assign PRDATA = prdata_reg;
  assign INSTR_ILLEGAL = illegal_reg;
  assign DM_WE = pend_reg;
  assign DM_WADDR = paddr_reg;
  assign DM_WBE = pbe_reg;
  assign DM_WDATA = pdata_reg;
  assign STATUS_FLAGS = sr_reg;
endmodule

// >>> verification/aad_datapath_props.sv
// port checker for the add/add_with_carry_op/and datapath slice
// assumes binding onto aad_datapath; sees only its ports
`timescale 1ns/1ps
module aad_datapath_chk
  import aad_pkg::*;
#(
  parameter int AW = DADDR_W
)
(
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic [7:0] PADDR,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic INSTR_VALID,
  input wire logic [INSTR_W-1:0] INSTR_WORD,
  input wire logic INSTR_ILLEGAL,
  input wire logic [AW-1:0] DM_RADDR,
  input wire logic [DW-1:0] DM_RDATA,
  input wire logic DM_WE,
  input wire logic [AW-1:0] DM_WADDR,
  input wire logic [1:0] DM_WBE,
  input wire logic [DW-1:0] DM_WDATA,
  input wire logic [SR_W-1:0] STATUS_FLAGS
);
  logic [1:0] fam;
  logic [2:0] form;
  logic legal;
  logic bad;
  logic apb_wr;
  logic [AW-1:0] fa;
  logic [1:0] lane;
  logic [2:0] kept;
  // decode of the word offered this cycle
  assign fam = INSTR_WORD[FAM_MSB:FAM_LSB];
  assign form = INSTR_WORD[FORM_MSB:FORM_LSB];
  assign legal = INSTR_VALID && fam <= FAM_AND && form <= FORM_SHORT_IMMEDIATE;
  assign bad = INSTR_VALID && !legal;
  assign apb_wr = PSEL && PENABLE && PWRITE;
  assign fa = AW'(INSTR_WORD[FA_MSB:FA_LSB]);
  assign lane = INSTR_WORD[BYTE_BIT] ? (INSTR_WORD[0] ? BE_HI : BE_LO) :
                BE_ALL;
  assign kept = {STATUS_FLAGS[SR_OV], STATUS_FLAGS[SR_DC],
                 STATUS_FLAGS[SR_C]};
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  file_raddr_a:
    assert property (legal && form <= FORM_F_TO_ACC |-> DM_RADDR == fa)
    else $error("file operand address wrong");
  one_cycle_a:
    assert property (legal && form == FORM_F_TO_F |=>
      DM_WE && DM_WADDR == $past(fa))
    else $error("file write not in next cycle");
  acc_dest_a:
    assert property (legal && (form == FORM_F_TO_ACC || form == FORM_TEN_BIT_IMMEDIATE)
      |=> !DM_WE)
    else $error("register destination wrote memory");
  byte_lane_a:
    assert property (legal && form == FORM_F_TO_F |=> DM_WBE == $past(lane))
    else $error("write lanes wrong");
  byte_copy_a:
    assert property (DM_WE && DM_WBE != BE_ALL |->
      DM_WDATA[15:8] == DM_WDATA[7:0])
    else $error("byte write data not on both lanes");
  illegal_flag_a:
    assert property (bad |=> INSTR_ILLEGAL && !DM_WE)
    else $error("illegal word not refused");
  no_false_a:
    assert property (!bad |=> !INSTR_ILLEGAL)
    else $error("spurious illegal flag");
  refuse_keep_a:
    assert property (bad && !apb_wr |=> $stable(STATUS_FLAGS))
    else $error("refused word changed status");
  and_keep_a:
    assert property (legal && fam == FAM_AND && !apb_wr |=>
      kept == $past(kept))
    else $error("and changed carry or overflow");
  sticky_zero_a:
    assert property (legal && fam == FAM_ADD_WITH_CARRY_OP && !STATUS_FLAGS[SR_Z] && !apb_wr
      |=> !STATUS_FLAGS[SR_Z])
    else $error("add with carry set zero flag");
endmodule

bind aad_datapath aad_datapath_chk #(.AW(AW)) i_chk (
  .MCLK(MCLK), .RSTN(RSTN), .PADDR(PADDR), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .INSTR_VALID(INSTR_VALID),
  .INSTR_WORD(INSTR_WORD), .INSTR_ILLEGAL(INSTR_ILLEGAL),
  .DM_RADDR(DM_RADDR), .DM_RDATA(DM_RDATA), .DM_WE(DM_WE),
  .DM_WADDR(DM_WADDR), .DM_WBE(DM_WBE), .DM_WDATA(DM_WDATA),
  .STATUS_FLAGS(STATUS_FLAGS)
);

// >>> verification/add_add_with_carry_op_and_datapath_bench.sv
// self-checking bench for the add/add_with_carry_op/and datapath slice
// assumes aad_pkg and aad_datapath; data memory is modelled here
`timescale 1ns/1ps
module add_add_with_carry_op_and_datapath_bench;
  import aad_pkg::*;
  logic MCLK = 1'b0;
  logic RSTN = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [31:0] PWDATA = 32'h0;
  logic INSTR_VALID = 1'b0;
  logic [23:0] INSTR_WORD = 24'h0;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, INSTR_ILLEGAL, DM_WE;
  logic [12:0] DM_RADDR, DM_WADDR;
  logic [1:0] DM_WBE;
  logic [15:0] DM_RDATA, DM_WDATA;
  logic [4:0] STATUS_FLAGS;
  logic [15:0] mem [0:4095];
  int fail_count = 0;
  int comparisons = 0;
  always #20 MCLK = ~MCLK;
  // combinational read, lane write at the edge
  assign DM_RDATA = mem[DM_RADDR[12:1]];
  always @(posedge MCLK) begin
    if (DM_WE && DM_WBE[0]) mem[DM_WADDR[12:1]][7:0] <= DM_WDATA[7:0];
    if (DM_WE && DM_WBE[1]) mem[DM_WADDR[12:1]][15:8] <= DM_WDATA[15:8];
  end
  aad_datapath i_dut (.MCLK(MCLK), .RSTN(RSTN), .PADDR(PADDR), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .INSTR_VALID(INSTR_VALID),
    .INSTR_WORD(INSTR_WORD), .INSTR_ILLEGAL(INSTR_ILLEGAL),
    .DM_RADDR(DM_RADDR), .DM_RDATA(DM_RDATA), .DM_WE(DM_WE),
    .DM_WADDR(DM_WADDR), .DM_WBE(DM_WBE), .DM_WDATA(DM_WDATA),
    .STATUS_FLAGS(STATUS_FLAGS));
  task automatic report_and_stop;
    if (fail_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask
  // one apb transfer, held until pready at an edge
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge MCLK);
    PSEL <= 1'b1;
    PADDR <= a;
    PWRITE <= w;
    PWDATA <= wd;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge MCLK);
      n++;
    end while (PREADY !== 1'b1 && n < 16);
    if (PREADY !== 1'b1) begin
      fail_count++;
      report_and_stop();
    end
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] i, input logic [15:0] v);
    logic [31:0] d;
    logic e;
    apb(1'b1, {2'b01, i, 2'b00}, {16'h0, v}, d, e);
  endtask
  task automatic chk_w(input logic [3:0] i, input logic [15:0] v);
    logic [31:0] d;
    logic e;
    apb(1'b0, {2'b01, i, 2'b00}, 32'h0, d, e);
    chk(d, {16'h0, v});
  endtask
  task automatic set_sr(input logic [4:0] v);
    logic [31:0] d;
    logic e;
    apb(1'b1, A_STATUS, 32'(v), d, e);
  endtask
  // one instruction offered for exactly one edge
  task automatic exec(input logic [23:0] w);
    @(posedge MCLK);
    INSTR_VALID <= 1'b1;
    INSTR_WORD <= w;
    @(posedge MCLK);
    INSTR_VALID <= 1'b0;
    #1;
  endtask
  function automatic logic [23:0] mk(input logic [1:0] f, input logic [2:0] m,
    input logic [3:0] wb, input logic b, input logic [13:0] lo);
    return {f, m, wb, b, lo};
  endfunction
  // reset values, readback and an unmapped place
  task automatic t_apb;
    logic [31:0] d;
    logic e;
    chk(32'(STATUS_FLAGS), 32'h0);
    chk_w(4'd3, 16'h0000);
    wr(4'd15, 16'ha5c3);
    chk_w(4'd15, 16'ha5c3);
    apb(1'b0, 8'h80, 32'h0, d, e);
    chk({d[30:0], e}, 32'h1);
  endtask
  // three-operand add into the top register
  task automatic t_reg;
    wr(4'd1, 16'h7fff);
    wr(4'd2, 16'h0001);
    exec(mk(FAM_ADD, FORM_REG, 4'd1, 1'b0,
      {AM_DIRECT, 4'd15, AM_DIRECT, 4'd2}));
    chk(32'(STATUS_FLAGS), 32'h0e);
    chk_w(4'd15, 16'h8000);
  endtask
  // carry in, largest word literal, sticky zero held
  task automatic t_add_with_carry_op;
    wr(4'd4, 16'hfc00);
    set_sr(5'h11);
    exec(mk(FAM_ADD_WITH_CARRY_OP, FORM_TEN_BIT_IMMEDIATE, 4'd0, 1'b0, {10'h3ff, 4'd4}));
    chk(32'(STATUS_FLAGS), 32'h13);
    chk_w(4'd4, 16'h0000);
  endtask
  // and with largest short literal keeps carry and overflow
  task automatic t_and;
    wr(4'd5, 16'h8001);
    set_sr(5'h0f);
    exec(mk(FAM_AND, FORM_SHORT_IMMEDIATE, 4'd5, 1'b0, {3'h0, 4'd6, 2'b00, 5'h1f}));
    chk(32'(STATUS_FLAGS), 32'h0b);
    chk_w(4'd6, 16'h0001);
  endtask
  // file forms at the top address, then to the accumulator
  task automatic t_file;
    mem[12'hfff] = 16'h1234;
    wr(4'd0, 16'h0001);
    exec(mk(FAM_ADD, FORM_F_TO_F, 4'd0, 1'b0, {1'b0, 13'h1ffe}));
    chk({DM_WE, DM_WBE, DM_WADDR, DM_WDATA},
      {1'b1, BE_ALL, 13'h1ffe, 16'h1235});
    exec(mk(FAM_ADD, FORM_F_TO_ACC, 4'd0, 1'b0, {1'b0, 13'h1ffe}));
    chk(32'(DM_WE), 32'h0);
    chk_w(4'd0, 16'h1236);
  endtask
  // byte size on a register and on an odd file byte
  task automatic t_byte;
    wr(4'd6, 16'h12ff);
    exec(mk(FAM_ADD, FORM_TEN_BIT_IMMEDIATE, 4'd0, 1'b1, {10'h001, 4'd6}));
    chk(32'(STATUS_FLAGS), 32'h13);
    chk_w(4'd6, 16'h1200);
    mem[12'h010] = 16'h7f00;
    exec(mk(FAM_ADD, FORM_F_TO_F, 4'd0, 1'b1, {1'b0, 13'h0021}));
    chk({DM_WE, DM_WBE, DM_WADDR, DM_WDATA},
      {1'b1, BE_HI, 13'h0021, 16'hb5b5});
    chk(32'(STATUS_FLAGS), 32'h0e);
  endtask
  // every indirect source mode, then a pre-decremented destination
  task automatic t_modes;
    logic [2:0] m [5] = '{AM_IND, AM_POSTINC, AM_POSTDEC, AM_PREINC,
                          AM_PREDEC};
    int d [5] = '{0, 2, -2, 2, -2};
    logic [15:0] p, ea;
    mem[12'h01f] = 16'h000a;
    mem[12'h020] = 16'h0014;
    mem[12'h021] = 16'h001e;
    wr(4'd1, 16'h0003);
    for (int k = 0; k < 5; k++) begin
      wr(4'd7, 16'h0040);
      exec(mk(FAM_ADD, FORM_REG, 4'd1, 1'b0, {AM_DIRECT, 4'd9, m[k], 4'd7}));
      p = 16'(16'h0040 + d[k]);
      ea = (k > 2) ? p : 16'h0040;
      chk_w(4'd9, 16'h0003 + mem[ea[12:1]]);
      chk_w(4'd7, p);
    end
    wr(4'd8, 16'h0050);
    exec(mk(FAM_ADD, FORM_REG, 4'd1, 1'b0,
      {AM_PREDEC, 4'd8, AM_DIRECT, 4'd1}));
    chk({DM_WE, DM_WBE, DM_WADDR, DM_WDATA},
      {1'b1, BE_ALL, 13'h004e, 16'h0006});
    chk_w(4'd8, 16'h004e);
  endtask
  // unknown family and unknown form are refused
  task automatic t_illegal;
    logic [4:0] s;
    s = STATUS_FLAGS;
    exec(24'hc00000);
    chk({INSTR_ILLEGAL, DM_WE, STATUS_FLAGS}, {25'h0, 1'b1, 1'b0, s});
    exec(mk(FAM_ADD, 3'h5, 4'd0, 1'b0, 14'h0));
    chk({INSTR_ILLEGAL, DM_WE, STATUS_FLAGS}, {25'h0, 1'b1, 1'b0, s});
  endtask
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 16'h0000;
    end
    repeat (10) @(posedge MCLK);
    RSTN <= 1'b1;
    t_apb();
    t_reg();
    t_add_with_carry_op();
    t_and();
    t_file();
    t_byte();
    t_modes();
    t_illegal();
    report_and_stop();
  end
endmodule
